/* File: inc/flash_cmd_if.sv */
// byte-serial carrier of one explicit frame payload in each direction
// assumes: both ends on the same clock; the requester always takes response bytes
`timescale 1ns/1ps

interface flash_cmd_if;
  // request path, requester to server
  logic        req_valid;
  logic        req_ready;
  logic [7:0]  req_byte;
  logic        req_last;
  logic [15:0] req_cluster;
  logic [7:0]  req_dst_ep;
  logic [7:0]  req_src_ep;
  logic        req_bcast;
  // response path, server to requester
  logic        rsp_valid;
  logic [7:0]  rsp_byte;
  logic        rsp_last;
  logic [7:0]  rsp_dst_ep;

  modport server (
    input  req_valid, req_byte, req_last, req_cluster, req_dst_ep, req_src_ep, req_bcast,
    output req_ready, rsp_valid, rsp_byte, rsp_last, rsp_dst_ep
  );

  modport requester (
    output req_valid, req_byte, req_last, req_cluster, req_dst_ep, req_src_ep, req_bcast,
    input  req_ready, rsp_valid, rsp_byte, rsp_last, rsp_dst_ep
  );
endinterface : flash_cmd_if

/* File: inc/flash_cmd_params.svh */
// constants of the flash block command server and its requester
// assumes: included by the package and the design files by bare name
`ifndef FLASH_CMD_PARAMS_SVH
`define FLASH_CMD_PARAMS_SVH

// store geometry
`define FC_NUM_BLOCKS      16'h0077
`define FC_BLOCK_SIZE      16'h0200
`define FC_BLOCK_IDX_W     7

// addressing of storage commands
`define FC_CLUSTER_ID      16'h0023
`define FC_DEVICE_EP       8'he6

// header layout, byte offsets in the payload
`define FC_OFS_CODE        4'h0
`define FC_OFS_OPTIONS     4'h1
`define FC_OFS_BLOCK       4'h2
`define FC_OFS_INDEX       4'h4
`define FC_OFS_COUNT       4'h6
`define FC_HDR_LEN         4'h8

// command and response codes
`define FC_CMD_GEOMETRY    8'h00
`define FC_CMD_ERASE       8'h01
`define FC_CMD_WRITE       8'h02
`define FC_CMD_ERASE_WRITE 8'h03
`define FC_CMD_READ        8'h04
`define FC_RSP_FLAG        8'h80
`define FC_RSP_GEOMETRY    8'h80
`define FC_RSP_ERASE       8'h81

// status byte: bit 0 is the error flag, the rest reads zero
`define FC_STATUS_OK       8'h00
`define FC_STATUS_ERR      8'h01

`endif

/* File: inc/flash_cmd_pkg.sv */
// types and header packing shared by both ends of the storage command link
// assumes: flash_cmd_params.svh on the include path
`include "flash_cmd_params.svh"

package flash_cmd_pkg;

  typedef struct packed {
    logic [7:0]  code;
    logic [7:0]  opt_status;
    logic [15:0] block;
    logic [15:0] index;
    logic [15:0] count;
  } hdr_s;

  typedef enum logic [1:0] {
    SRV_RX    = 2'b00,
    SRV_EXEC  = 2'b01,
    SRV_ERASE = 2'b11,
    SRV_TX    = 2'b10
  } srv_state_e;

  typedef enum logic [1:0] {
    REQ_IDLE = 2'b00,
    REQ_SEND = 2'b01
  } req_state_e;

  // header goes on the wire first byte first, so every 16-bit field is msb first
  function automatic logic [7:0] hdr_byte(input hdr_s h, input logic [3:0] idx);
    logic [63:0] flat;
    flat = h;
    hdr_byte = flat[8'(7 - idx) * 8 +: 8];
  endfunction : hdr_byte

  function automatic hdr_s hdr_shift(input hdr_s h, input logic [7:0] b);
    logic [63:0] flat;
    flat = h;
    hdr_shift = {flat[55:0], b};
  endfunction : hdr_shift

endpackage : flash_cmd_pkg

/* File: rtl/flash_cmd_requester.sv */
// requester end: frames storage commands and hands replies to its host
// assumes: server end on the same clock; response bytes are always taken
`timescale 1ns/1ps
`include "flash_cmd_params.svh"

module flash_cmd_requester (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // link to the server
  flash_cmd_if.requester   link,
  // host command side
  input  wire logic        cmd_valid_i,
  input  wire logic [7:0]  cmd_code_i,
  input  wire logic [15:0] cmd_block_i,
  input  wire logic [15:0] cmd_count_i,
  input  wire logic        cmd_bcast_i,
  input  wire logic [7:0]  cmd_src_ep_i,
  output logic             cmd_ready_o,
  // host mode
  input  wire logic        api_mode_i,
  input  wire logic        explicit_out_i,
  // receive indicator to the host
  output logic             rx_ind_valid_o,
  output logic [7:0]       rx_code_o,
  output logic [7:0]       rx_status_o,
  output logic [15:0]      rx_block_o,
  output logic [15:0]      rx_index_o,
  output logic [15:0]      rx_count_o
);

  flash_cmd_pkg::req_state_e state_reg;
  flash_cmd_pkg::hdr_s       tx_hdr_reg;
  flash_cmd_pkg::hdr_s       rx_hdr_reg;
  flash_cmd_pkg::hdr_s       rx_hdr_next;
  logic [3:0]                tx_cnt_reg;

  // command framing: options and start index are always zero, no data bytes
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg        <= flash_cmd_pkg::REQ_IDLE;
      tx_hdr_reg       <= '0;
      tx_cnt_reg       <= 4'h0;
      cmd_ready_o      <= 1'b0;
      link.req_valid   <= 1'b0;
      link.req_byte    <= 8'h00;
      link.req_last    <= 1'b0;
      link.req_cluster <= 16'h0000;
      link.req_dst_ep  <= 8'h00;
      link.req_src_ep  <= 8'h00;
      link.req_bcast   <= 1'b0;
    end else begin
      case (state_reg)
        flash_cmd_pkg::REQ_IDLE: begin
          cmd_ready_o <= 1'b1;
          if (cmd_valid_i && cmd_ready_o) begin
            cmd_ready_o      <= 1'b0;
            tx_hdr_reg.code  <= cmd_code_i;
            tx_hdr_reg.opt_status <= 8'h00;
            tx_hdr_reg.block <= cmd_block_i;
            tx_hdr_reg.index <= 16'h0000;
            tx_hdr_reg.count <= cmd_count_i;
            tx_cnt_reg       <= 4'h0;
            link.req_cluster <= `FC_CLUSTER_ID;
            link.req_dst_ep  <= `FC_DEVICE_EP;
            link.req_src_ep  <= cmd_src_ep_i;
            link.req_bcast   <= cmd_bcast_i;
            state_reg        <= flash_cmd_pkg::REQ_SEND;
          end
        end
        flash_cmd_pkg::REQ_SEND: begin
          if (!link.req_valid || link.req_ready) begin
            if (link.req_valid && link.req_last) begin
              link.req_valid <= 1'b0;
              link.req_last  <= 1'b0;
              state_reg      <= flash_cmd_pkg::REQ_IDLE;
            end else begin
              link.req_valid <= 1'b1;
              link.req_byte  <= flash_cmd_pkg::hdr_byte(tx_hdr_reg, tx_cnt_reg);
              link.req_last  <= (tx_cnt_reg == `FC_HDR_LEN - 4'h1);
              tx_cnt_reg     <= tx_cnt_reg + 4'h1;
            end
          end
        end
        default: begin
          state_reg <= flash_cmd_pkg::REQ_IDLE;
        end
      endcase
    end
  end

  assign rx_hdr_next = flash_cmd_pkg::hdr_shift(rx_hdr_reg, link.rsp_byte);

  // reply intake; the last byte completes the header in the same cycle
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_hdr_reg     <= '0;
      rx_ind_valid_o <= 1'b0;
      rx_code_o      <= 8'h00;
      rx_status_o    <= 8'h00;
      rx_block_o     <= 16'h0000;
      rx_index_o     <= 16'h0000;
      rx_count_o     <= 16'h0000;
    end else begin
      rx_ind_valid_o <= 1'b0;
      if (link.rsp_valid) begin
        rx_hdr_reg <= rx_hdr_next;
        if (link.rsp_last && api_mode_i &&
            (link.rsp_dst_ep == `FC_DEVICE_EP || explicit_out_i)) begin
          rx_ind_valid_o <= 1'b1;
          rx_code_o      <= rx_hdr_next.code;
          rx_status_o    <= rx_hdr_next.opt_status;
          rx_block_o     <= rx_hdr_next.block;
          rx_index_o     <= rx_hdr_next.index;
          rx_count_o     <= rx_hdr_next.count;
        end
      end
    end
  end

endmodule : flash_cmd_requester

/* File: rtl/flash_cmd_server.sv */
// device end: decodes storage command payloads, erases flash, answers unicasts
// assumes: one payload per frame, header bytes first; flash erase macro outside
`timescale 1ns/1ps
`include "flash_cmd_params.svh"

module flash_cmd_server (
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       sys_rst_i,
  // link to the requester
  flash_cmd_if.server                     link,
  // flash erase port
  output logic                            erase_req_o,
  output logic [`FC_BLOCK_IDX_W-1:0]      erase_block_o,
  input  wire logic                       erase_ack_i,
  // status
  output logic                            busy_o,
  output logic                            cmd_done_o,
  output logic                            cmd_error_o
);

  flash_cmd_pkg::srv_state_e state_reg;
  flash_cmd_pkg::hdr_s       hdr_reg;
  flash_cmd_pkg::hdr_s       rsp_reg;
  logic [3:0]                rx_cnt_reg;
  logic [3:0]                tx_cnt_reg;
  logic                      accept_reg;
  logic                      bcast_reg;
  logic [7:0]                src_ep_reg;
  logic                      ready_reg;
  logic                      erase_start;
  logic                      erase_done;
  logic                      erase_all;
  logic                      block_bad;
  logic                      frame_ours;

  assign frame_ours = (link.req_cluster == `FC_CLUSTER_ID) &&
                      (link.req_dst_ep == `FC_DEVICE_EP);
  assign block_bad  = (hdr_reg.block >= `FC_NUM_BLOCKS);
  assign erase_all  = (hdr_reg.count == 16'h0000);
  // a dropped frame must never reach the flash, so acceptance gates the erase
  assign erase_start = (state_reg == flash_cmd_pkg::SRV_EXEC) && accept_reg &&
                       (hdr_reg.code == `FC_CMD_ERASE) &&
                       (erase_all || !block_bad);

  // request intake: header bytes shift in, trailing data is swallowed
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hdr_reg    <= '0;
      rx_cnt_reg <= 4'h0;
      accept_reg <= 1'b0;
      bcast_reg  <= 1'b0;
      src_ep_reg <= 8'h00;
    end else if (state_reg == flash_cmd_pkg::SRV_RX && link.req_valid && ready_reg) begin
      if (rx_cnt_reg < `FC_HDR_LEN) begin
        hdr_reg    <= flash_cmd_pkg::hdr_shift(hdr_reg, link.req_byte);
        rx_cnt_reg <= rx_cnt_reg + 4'h1;
      end
      if (link.req_last) begin
        // a frame shorter than the header is dropped silently
        accept_reg <= frame_ours && (rx_cnt_reg >= `FC_HDR_LEN - 4'h1);
        bcast_reg  <= link.req_bcast;
        src_ep_reg <= link.req_src_ep;
        rx_cnt_reg <= 4'h0;
      end
    end
  end

  // control sequence
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= flash_cmd_pkg::SRV_RX;
      ready_reg <= 1'b0;
    end else begin
      case (state_reg)
        flash_cmd_pkg::SRV_RX: begin
          ready_reg <= 1'b1;
          if (link.req_valid && ready_reg && link.req_last) begin
            ready_reg <= 1'b0;
            state_reg <= flash_cmd_pkg::SRV_EXEC;
          end
        end
        flash_cmd_pkg::SRV_EXEC: begin
          if (!accept_reg) begin
            state_reg <= flash_cmd_pkg::SRV_RX;
          end else if (erase_start) begin
            state_reg <= flash_cmd_pkg::SRV_ERASE;
          end else if (bcast_reg) begin
            state_reg <= flash_cmd_pkg::SRV_RX;
          end else begin
            state_reg <= flash_cmd_pkg::SRV_TX;
          end
        end
        flash_cmd_pkg::SRV_ERASE: begin
          if (erase_done) begin
            state_reg <= bcast_reg ? flash_cmd_pkg::SRV_RX :
                                     flash_cmd_pkg::SRV_TX;
          end
        end
        flash_cmd_pkg::SRV_TX: begin
          if (tx_cnt_reg == `FC_HDR_LEN - 4'h1) begin
            state_reg <= flash_cmd_pkg::SRV_RX;
          end
        end
        default: begin
          state_reg <= flash_cmd_pkg::SRV_RX;
        end
      endcase
    end
  end

  // response header is built while the command executes
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rsp_reg <= '0;
    end else if (state_reg == flash_cmd_pkg::SRV_EXEC) begin
      rsp_reg.code  <= hdr_reg.code | `FC_RSP_FLAG;
      rsp_reg.block <= hdr_reg.block;
      rsp_reg.index <= hdr_reg.index;
      rsp_reg.count <= 16'h0000;
      case (hdr_reg.code)
        `FC_CMD_GEOMETRY: begin
          rsp_reg.opt_status <= `FC_STATUS_OK;
          rsp_reg.block      <= `FC_NUM_BLOCKS;
          rsp_reg.index      <= `FC_BLOCK_SIZE;
        end
        `FC_CMD_ERASE: begin
          // start index is echoed but never used to address flash
          rsp_reg.opt_status <= (!erase_all && block_bad) ? `FC_STATUS_ERR :
                                                            `FC_STATUS_OK;
        end
        default: begin
          // write and read paths are not built here; they are refused
          rsp_reg.opt_status <= `FC_STATUS_ERR;
        end
      endcase
    end
  end

  // response serializer
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_cnt_reg      <= 4'h0;
      link.rsp_valid  <= 1'b0;
      link.rsp_byte   <= 8'h00;
      link.rsp_last   <= 1'b0;
      link.rsp_dst_ep <= 8'h00;
    end else begin
      link.rsp_valid <= 1'b0;
      link.rsp_last  <= 1'b0;
      if (state_reg == flash_cmd_pkg::SRV_TX) begin
        link.rsp_valid  <= 1'b1;
        link.rsp_byte   <= flash_cmd_pkg::hdr_byte(rsp_reg, tx_cnt_reg);
        link.rsp_last   <= (tx_cnt_reg == `FC_HDR_LEN - 4'h1);
        link.rsp_dst_ep <= src_ep_reg;
        tx_cnt_reg      <= (tx_cnt_reg == `FC_HDR_LEN - 4'h1) ? 4'h0 : tx_cnt_reg + 4'h1;
      end
    end
  end

  // status outputs
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      busy_o      <= 1'b0;
      cmd_done_o  <= 1'b0;
      cmd_error_o <= 1'b0;
    end else begin
      busy_o      <= (state_reg != flash_cmd_pkg::SRV_RX);
      cmd_done_o  <= 1'b0;
      cmd_error_o <= 1'b0;
      if ((state_reg == flash_cmd_pkg::SRV_EXEC && accept_reg && !erase_start) ||
          (state_reg == flash_cmd_pkg::SRV_ERASE && erase_done)) begin
        cmd_done_o  <= 1'b1;
        cmd_error_o <= (hdr_reg.code == `FC_CMD_ERASE) ? (!erase_all && block_bad) :
                       (hdr_reg.code != `FC_CMD_GEOMETRY);
      end
    end
  end

  assign link.req_ready = ready_reg;

  flash_erase_walker u_erase (
    .sys_clk_i     (sys_clk_i),
    .sys_rst_i     (sys_rst_i),
    .start_i       (erase_start),
    .all_i         (erase_all),
    .block_i       (hdr_reg.block[`FC_BLOCK_IDX_W-1:0]),
    .done_o        (erase_done),
    .erase_req_o   (erase_req_o),
    .erase_block_o (erase_block_o),
    .erase_ack_i   (erase_ack_i)
  );

endmodule : flash_cmd_server

/* File: rtl/flash_erase_walker.sv */
// walks one block or the whole store through the flash erase handshake
// assumes: the flash macro holds erase_ack_i high for one cycle per block done
`timescale 1ns/1ps
`include "flash_cmd_params.svh"

module flash_erase_walker (
  // clock and reset
  input  wire logic                       sys_clk_i,
  input  wire logic                       sys_rst_i,
  // command side
  input  wire logic                       start_i,
  input  wire logic                       all_i,
  input  wire logic [`FC_BLOCK_IDX_W-1:0] block_i,
  output logic                            done_o,
  // flash side
  output logic                            erase_req_o,
  output logic [`FC_BLOCK_IDX_W-1:0]      erase_block_o,
  input  wire logic                       erase_ack_i
);

  localparam logic [`FC_BLOCK_IDX_W-1:0] LAST_BLOCK = `FC_BLOCK_IDX_W'(`FC_NUM_BLOCKS - 16'h1);

  logic all_reg;

  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      erase_req_o   <= 1'b0;
      erase_block_o <= '0;
      all_reg       <= 1'b0;
      done_o        <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !erase_req_o) begin
        erase_req_o   <= 1'b1;
        all_reg       <= all_i;
        erase_block_o <= all_i ? '0 : block_i;
      end else if (erase_req_o && erase_ack_i) begin
        // whole-store erase steps through every block in turn
        if (all_reg && erase_block_o != LAST_BLOCK) begin
          erase_block_o <= erase_block_o + 1'b1;
        end else begin
          erase_req_o <= 1'b0;
          done_o      <= 1'b1;
        end
      end
    end
  end

endmodule : flash_erase_walker

/* File: tb/flash_block_command_server_bench.sv */
// bench: requester and server joined by the carrier, host side driven here
// assumes: flash macro modelled by a one-cycle ack per erased block, every other cycle while erase_req_o is high
`timescale 1ns/1ps

module flash_block_command_server_bench;
  logic        sys_clk_i, sys_rst_i, cmd_valid_i, cmd_bcast_i, cmd_ready_o;
  logic [7:0]  cmd_code_i, cmd_src_ep_i, rx_code_o, rx_status_o, last_ep, dst_seen;
  logic [15:0] cmd_block_i, cmd_count_i, rx_block_o, rx_index_o, rx_count_o;
  logic        api_mode_i, explicit_out_i, rx_ind_valid_o, erase_req_o, erase_ack_i, cmd_done_o;
  logic        busy_o, cmd_error_o, err_seen, busy_seen;
  logic [6:0]  erase_block_o;
  logic [7:0]  rsp_buf [16];
  int          err_total, compares, rsp_n, rx_n, ers_n, ers_sum, done_n;

  flash_cmd_if link_if ();
  flash_cmd_server flash_cmd_server_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .link(link_if.server), .erase_req_o(erase_req_o), .erase_block_o(erase_block_o),
    .erase_ack_i(erase_ack_i), .busy_o(busy_o), .cmd_done_o(cmd_done_o),
    .cmd_error_o(cmd_error_o));
  flash_cmd_requester flash_cmd_requester_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .link(link_if.requester), .cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i),
    .cmd_block_i(cmd_block_i), .cmd_count_i(cmd_count_i), .cmd_bcast_i(cmd_bcast_i),
    .cmd_src_ep_i(cmd_src_ep_i), .cmd_ready_o(cmd_ready_o), .api_mode_i(api_mode_i),
    .explicit_out_i(explicit_out_i), .rx_ind_valid_o(rx_ind_valid_o), .rx_code_o(rx_code_o),
    .rx_status_o(rx_status_o), .rx_block_o(rx_block_o), .rx_index_o(rx_index_o),
    .rx_count_o(rx_count_o));
  flash_cmd_chk flash_cmd_chk_inst (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
    .req_valid(link_if.req_valid), .req_ready(link_if.req_ready),
    .req_byte(link_if.req_byte), .req_last(link_if.req_last),
    .req_cluster(link_if.req_cluster), .req_dst_ep(link_if.req_dst_ep),
    .req_src_ep(link_if.req_src_ep), .req_bcast(link_if.req_bcast),
    .rsp_valid(link_if.rsp_valid), .rsp_byte(link_if.rsp_byte),
    .rsp_last(link_if.rsp_last), .rsp_dst_ep(link_if.rsp_dst_ep));

  always #4 sys_clk_i = ~sys_clk_i;

  // flash acks each request one cycle after it rises, then lets it drop
  always @(posedge sys_clk_i) erase_ack_i <= erase_req_o && !erase_ack_i;

  always @(posedge sys_clk_i) begin
    if (link_if.rsp_valid === 1'b1 && rsp_n < 16) begin
      rsp_buf[rsp_n] = link_if.rsp_byte;
      rsp_n++;
      dst_seen = link_if.rsp_dst_ep;
    end
    if (erase_req_o === 1'b1 && erase_ack_i === 1'b1) begin
      ers_n++;
      ers_sum += int'(erase_block_o);
    end
    if (rx_ind_valid_o === 1'b1) rx_n++;
    if (cmd_done_o === 1'b1) begin
      done_n++;
      err_seen = cmd_error_o;
    end
    if (busy_o === 1'b1) busy_seen = 1'b1;
  end

  task automatic finish_test;
    if (err_total == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic issue(input logic [7:0] c, input logic [15:0] b, input logic [15:0] n,
                       input logic bc, input logic [7:0] ep);
    logic rdy;
    int   k;
    @(negedge sys_clk_i);
    {rsp_n, rx_n, ers_n, ers_sum, done_n} = '0;
    {err_seen, busy_seen} = 2'b00;
    last_ep = ep;
    @(posedge sys_clk_i);
    {cmd_valid_i, cmd_code_i, cmd_block_i, cmd_count_i, cmd_bcast_i} <= {1'b1, c, b, n, bc};
    cmd_src_ep_i <= ep;
    rdy = 1'b0;
    for (k = 0; k < 50 && !rdy; k++) begin
      @(negedge sys_clk_i);
      rdy = (cmd_ready_o === 1'b1);
      @(posedge sys_clk_i);
    end
    cmd_valid_i <= 1'b0;
    for (k = 0; k < 1000 && done_n == 0; k++) @(negedge sys_clk_i);
    if (!rdy || done_n == 0) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, {rdy, done_n != 0}, 2'b11);
      finish_test;
    end
    repeat (30) @(posedge sys_clk_i);
  endtask : issue

  task automatic expect_reply(input logic [7:0] c, input logic [7:0] st,
                              input logic [15:0] b, input logic [15:0] ix, input logic shown);
    check(16'(rsp_n), 16'h0008);
    check({rsp_buf[0], rsp_buf[1]}, {c, st});
    check({rsp_buf[2], rsp_buf[3]}, b);
    check({rsp_buf[4], rsp_buf[5]}, ix);
    check({rsp_buf[6], rsp_buf[7]}, 16'h0000);
    check({8'h00, dst_seen}, {8'h00, last_ep});
    check(16'(rx_n), {15'h0000, shown});
    check({14'h0000, err_seen, busy_o}, {14'h0000, st[0], 1'b0});
    check({15'h0000, busy_seen}, 16'h0001);
    if (shown) begin
      check({rx_code_o, rx_status_o}, {c, st});
      check(rx_block_o, b);
      check(rx_index_o, ix);
      check(rx_count_o, 16'h0000);
    end
  endtask : expect_reply

  task automatic test_erase(input logic [15:0] b, input logic [15:0] n, input logic [7:0] st,
                            input int cnt, input int sum);
    issue(8'h01, b, n, 1'b0, 8'he6);
    expect_reply(8'h81, st, b, 16'h0000, 1'b1);
    check(16'(ers_n), 16'(cnt));
    check(16'(ers_sum), 16'(sum));
  endtask : test_erase

  task automatic test_other_codes;
    logic [7:0] c;
    for (c = 8'h02; c <= 8'h04; c++) begin
      issue(c, 16'h0003, 16'h0010, 1'b0, 8'he6);
      expect_reply(c | 8'h80, 8'h01, 16'h0003, 16'h0000, 1'b1);
    end
  endtask : test_other_codes

  task automatic test_delivery(input logic a, input logic x, input logic [7:0] ep);
    @(posedge sys_clk_i);
    api_mode_i <= a;
    explicit_out_i <= x;
    issue(8'h00, 16'h0000, 16'h0000, 1'b0, ep);
    expect_reply(8'h80, 8'h00, 16'h0077, 16'h0200, a && (x || ep == 8'he6));
  endtask : test_delivery

  task automatic test_broadcast;
    issue(8'h00, 16'h0000, 16'h0000, 1'b1, 8'he6);
    check(16'(rsp_n + rx_n), 16'h0000);
  endtask : test_broadcast

  initial begin
    {sys_clk_i, cmd_valid_i, cmd_bcast_i, explicit_out_i, erase_ack_i} = '0;
    {cmd_code_i, cmd_src_ep_i, cmd_block_i, cmd_count_i} = '0;
    {err_total, compares, rsp_n, rx_n, ers_n, ers_sum, done_n} = '0;
    sys_rst_i = 1'b1;
    api_mode_i = 1'b1;
    repeat (10) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    test_delivery(1'b1, 1'b0, 8'he6);
    test_delivery(1'b0, 1'b1, 8'he6);
    test_delivery(1'b1, 1'b0, 8'h10);
    test_delivery(1'b1, 1'b1, 8'h10);
    test_erase(16'h0076, 16'h0200, 8'h00, 1, 118);
    test_erase(16'h0005, 16'h0000, 8'h00, 119, 7021);
    test_erase(16'h0077, 16'h0200, 8'h01, 0, 0);
    test_other_codes;
    test_broadcast;
    finish_test;
  end
endmodule : flash_block_command_server_bench

/* File: tb/flash_cmd_chk.sv */
// link checker: reply contents, routing and timing seen on the carrier
// assumes: instantiated beside the interface; one clock, async active-high reset
`timescale 1ns/1ps
`include "flash_cmd_params.svh"

module flash_cmd_chk (
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        sys_rst_i,
  // request path
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [7:0]  req_byte,
  input wire logic        req_last,
  input wire logic [15:0] req_cluster,
  input wire logic [7:0]  req_dst_ep,
  input wire logic [7:0]  req_src_ep,
  input wire logic        req_bcast,
  // response path
  input wire logic        rsp_valid,
  input wire logic [7:0]  rsp_byte,
  input wire logic        rsp_last,
  input wire logic [7:0]  rsp_dst_ep
);
  logic [3:0] rq_cnt_reg;
  logic [3:0] rs_cnt_reg;
  logic [7:0] hdr_reg [8];
  logic [7:0] ep_reg;
  logic       bcast_reg;
  wire        take = req_valid && req_ready;

  // the counter saturates so swallowed data bytes never overwrite the header copy
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rq_cnt_reg <= 4'h0;
    else if (take) rq_cnt_reg <= req_last ? 4'h0 : rq_cnt_reg + 4'((rq_cnt_reg < 4'h8));
  end
  always_ff @(posedge sys_clk_i) begin
    if (take && rq_cnt_reg < 4'h8) hdr_reg[rq_cnt_reg[2:0]] <= req_byte;
  end
  always_ff @(posedge sys_clk_i) begin
    if (take) ep_reg <= req_src_ep;
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) bcast_reg <= 1'b0;
    else if (take) bcast_reg <= req_bcast;
  end
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) rs_cnt_reg <= 4'h0;
    else if (rsp_valid) rs_cnt_reg <= rsp_last ? 4'h0 : rs_cnt_reg + 4'h1;
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  chk_reply_code: assert property (
    rsp_valid && rs_cnt_reg == 4'h0 |-> rsp_byte == (hdr_reg[0] | `FC_RSP_FLAG))
    else $error("reply code does not match request");
  chk_status_bits: assert property (
    rsp_valid && rs_cnt_reg == 4'h1 |-> rsp_byte[7:1] == 7'h00
      && (hdr_reg[0] != `FC_CMD_GEOMETRY || !rsp_byte[0]))
    else $error("status byte has reserved or wrong bits");
  chk_geometry_fields: assert property (
    rsp_valid && rs_cnt_reg == 4'h2 && hdr_reg[0] == `FC_CMD_GEOMETRY |->
      rsp_byte == 8'h00 ##1 rsp_byte == 8'h77 ##1 rsp_byte == 8'h02 ##1 rsp_byte == 8'h00)
    else $error("geometry fields wrong");
  chk_erase_echo: assert property (
    rsp_valid && rs_cnt_reg == 4'h2 && hdr_reg[0] == `FC_CMD_ERASE |->
      rsp_byte == hdr_reg[2] ##1 rsp_byte == hdr_reg[3] ##1 rsp_byte == hdr_reg[4]
      ##1 rsp_byte == hdr_reg[5])
    else $error("erase reply does not echo block and index");
  chk_count_zero: assert property (
    rsp_valid && rs_cnt_reg == 4'h6 |-> rsp_byte == 8'h00 ##1 rsp_byte == 8'h00 && rsp_last)
    else $error("reply count not zero or length wrong");
  chk_reply_burst: assert property (
    rsp_valid && !rsp_last |=> rsp_valid)
    else $error("reply bytes not back to back");
  chk_reply_dest: assert property (
    rsp_valid |-> rsp_dst_ep == ep_reg)
    else $error("reply not sent to source endpoint");
  chk_no_bcast_reply: assert property (
    rsp_valid |-> !bcast_reg)
    else $error("broadcast request answered");
  chk_reply_start: assert property (
    take && req_last && hdr_reg[0] != `FC_CMD_ERASE && !req_bcast
      && req_cluster == `FC_CLUSTER_ID && req_dst_ep == `FC_DEVICE_EP |-> ##3 rsp_valid)
    else $error("unicast reply missing or late");

  cov_geometry: cover property (rsp_valid && rs_cnt_reg == 4'h0 && rsp_byte == 8'h80);
  cov_erase: cover property (rsp_valid && rs_cnt_reg == 4'h0 && rsp_byte == 8'h81);
  cov_bcast: cover property (take && req_last && req_bcast);
endmodule : flash_cmd_chk
